//--- logic/mcsd_defines.svh
// Purpose: constants for the memory chip-select decoder
// Assumes: 16-bit control registers, 20-bit addresses
// Notes: offsets are byte offsets inside the control block
`ifndef MCSD_DEFINES_SVH
`define MCSD_DEFINES_SVH
`define MCSD_OFF_UPPER 8'hA0
`define MCSD_OFF_LOWER 8'hA2
`define MCSD_OFF_MIDBASE 8'hA6
`define MCSD_OFF_MIDSIZE 8'hA8
`define MCSD_UPPER_RESET 16'hFFFB
`define MCSD_RDY_IGNORE_BIT 2
`define MCSD_MIDSIZE_LSB 8
`define MCSD_MIDSIZE_MSB 14
`define MCSD_MIDBASE_LSB 9
`define MCSD_LIMIT_LSB 6
`endif

//--- logic/mcsd_pkg.sv
// Purpose: shared types for the memory chip-select decoder
// Assumes: none
// Notes: none
package mcsd_pkg;
  typedef struct packed {
    logic [7:0] offset;
    logic [15:0] data;
    logic wr;
    logic rd;
  } mcsd_reg_req_type;
  typedef struct packed {
    logic [19:0] addr;
    logic start;
    logic active;
  } mcsd_cycle_type;
  typedef logic [2:0] mcsd_ready_mode_type;
endpackage : mcsd_pkg

//--- logic/mcsd_range_match.sv
// Purpose: combinational area match for the live cycle address
// Assumes: registers are legal values
// Notes: none
`timescale 1ns/1ps
`include "mcsd_defines.svh"
module mcsd_range_match (
  input wire logic [19:0] addr,
  input wire logic [15:0] upper_reg,
  input wire logic [15:0] lower_reg,
  input wire logic [15:0] base_reg,
  input wire logic [15:0] size_reg,
  output logic hit_upper,
  output logic hit_lower,
  output logic [3:0] hit_mid
);
  import mcsd_pkg::*;
  logic [15:0] up16;
  logic [6:0] sz;
  logic [19:0] base;
  logic [19:0] span;
  logic [19:0] off;
  logic [19:0] qtr;
  assign up16 = addr[19:4];
  assign hit_upper = up16 >= {upper_reg[15:`MCSD_LIMIT_LSB], 6'h00};
  assign hit_lower = up16 <= {lower_reg[15:`MCSD_LIMIT_LSB], 6'h3F};
  assign base = {base_reg[15:`MCSD_MIDBASE_LSB], 13'h0000};
  assign sz = size_reg[`MCSD_MIDSIZE_MSB:`MCSD_MIDSIZE_LSB];
  assign span = {sz, 13'h0000};
  assign off = addr - base;
  assign qtr = {2'h0, span[19:2]};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_q
      assign hit_mid[g] = (addr >= base) && (off < span) &&
        (off >= 20'(qtr * g)) && (off < 20'(qtr * (g + 1)));
    end
  endgenerate
endmodule : mcsd_range_match

//--- logic/mcsd_top.sv
// Purpose: memory chip-select decoder with ready generation
// Assumes: CPU writes registers through the control block port
// Notes: outputs registered; selects valid one clock after start
`timescale 1ns/1ps
`include "mcsd_defines.svh"
module mcsd_top (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire mcsd_pkg::mcsd_reg_req_type REG_REQ,
  output logic [15:0] REG_RDATA,
  input wire mcsd_pkg::mcsd_cycle_type CYCLE,
  input wire logic EXT_READY,
  output logic UPPER_AREA_SELECT_N,
  output logic LOWER_AREA_SELECT_N,
  output logic [3:0] MID_AREA_SELECTS_N,
  output logic BUS_READY,
  output logic [2:0] AREA_READY_MODE
);
  import mcsd_pkg::*;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] upper_area_limit_q;
  logic [15:0] lower_area_limit_q;
  logic [15:0] mid_area_base_q;
  logic [15:0] mid_area_size_q;
  logic lower_seen_q;
  logic base_seen_q;
  logic size_seen_q;
  logic acc;

  function automatic logic hit_off(input mcsd_reg_req_type r, input logic [7:0] off);
    hit_off = (r.wr || r.rd) && (r.offset == off);
  endfunction : hit_off

  assign acc = REG_REQ.wr || REG_REQ.rd;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      upper_area_limit_q <= `MCSD_UPPER_RESET;
    end else if (REG_REQ.wr && REG_REQ.offset == `MCSD_OFF_UPPER) begin
      upper_area_limit_q <= REG_REQ.data;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      lower_area_limit_q <= 16'h0000;
      mid_area_base_q <= 16'h0000;
      mid_area_size_q <= 16'h0000;
    end else if (REG_REQ.wr) begin
      if (REG_REQ.offset == `MCSD_OFF_LOWER) begin
        lower_area_limit_q <= REG_REQ.data;
      end
      if (REG_REQ.offset == `MCSD_OFF_MIDBASE) begin
        mid_area_base_q <= REG_REQ.data;
      end
      if (REG_REQ.offset == `MCSD_OFF_MIDSIZE) begin
        mid_area_size_q <= REG_REQ.data;
      end
    end
  end

  // a read or write at the lower, base or size register offset arms that area; upper is never gated; mid needs both base and size
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      lower_seen_q <= 1'b0;
      base_seen_q <= 1'b0;
      size_seen_q <= 1'b0;
    end else if (acc) begin
      if (hit_off(REG_REQ, `MCSD_OFF_LOWER)) begin
        lower_seen_q <= 1'b1;
      end
      if (hit_off(REG_REQ, `MCSD_OFF_MIDBASE)) begin
        base_seen_q <= 1'b1;
      end
      if (hit_off(REG_REQ, `MCSD_OFF_MIDSIZE)) begin
        size_seen_q <= 1'b1;
      end
    end
  end

  // Unmapped offsets read zero
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_REQ.rd) begin
      case (REG_REQ.offset)
        `MCSD_OFF_UPPER: begin
          REG_RDATA <= upper_area_limit_q;
        end
        `MCSD_OFF_LOWER: begin
          REG_RDATA <= lower_area_limit_q;
        end
        `MCSD_OFF_MIDBASE: begin
          REG_RDATA <= mid_area_base_q;
        end
        `MCSD_OFF_MIDSIZE: begin
          REG_RDATA <= mid_area_size_q;
        end
        default: begin
          REG_RDATA <= 16'h0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic hit_upper;
  logic hit_lower;
  logic [3:0] hit_mid;

  mcsd_range_match u_match (
    .addr(CYCLE.addr),
    .upper_reg(upper_area_limit_q),
    .lower_reg(lower_area_limit_q),
    .base_reg(mid_area_base_q),
    .size_reg(mid_area_size_q),
    .hit_upper(hit_upper),
    .hit_lower(hit_lower),
    .hit_mid(hit_mid)
  );

  logic sel_u_d;
  logic sel_l_d;
  logic [3:0] sel_m_d;
  logic mid_armed;
  assign mid_armed = base_seen_q && size_seen_q;
  assign sel_u_d = hit_upper;
  assign sel_l_d = hit_lower && lower_seen_q;
  assign sel_m_d = mid_armed ? hit_mid : 4'h0;

  // ----------------------------------------
  // Select outputs
  // ----------------------------------------
  // Latched at start so later register writes cannot glitch a cycle
  logic [5:0] sel_q;
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= 6'h00;
    end else if (CYCLE.start) begin
      sel_q <= {sel_m_d, sel_l_d, sel_u_d};
    end else if (!CYCLE.active) begin
      sel_q <= 6'h00;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      UPPER_AREA_SELECT_N <= 1'b1;
      LOWER_AREA_SELECT_N <= 1'b1;
      MID_AREA_SELECTS_N <= 4'hF;
    end else if (CYCLE.start) begin
      UPPER_AREA_SELECT_N <= !sel_u_d;
      LOWER_AREA_SELECT_N <= !sel_l_d;
      MID_AREA_SELECTS_N <= ~sel_m_d;
    end else if (!CYCLE.active) begin
      UPPER_AREA_SELECT_N <= 1'b1;
      LOWER_AREA_SELECT_N <= 1'b1;
      MID_AREA_SELECTS_N <= 4'hF;
    end
  end

  // ----------------------------------------
  // Ready generation
  // ----------------------------------------
  mcsd_ready_mode_type mode_d;
  mcsd_ready_mode_type mode_q;
  logic any_sel_d;
  logic start_q;
  logic rdy;

  always_comb begin
    mode_d = 3'h4;
    if (sel_u_d) begin
      mode_d = upper_area_limit_q[2:0];
    end else if (sel_l_d) begin
      mode_d = lower_area_limit_q[2:0];
    end else if (sel_m_d != 4'h0) begin
      mode_d = mid_area_base_q[2:0];
    end
  end
  assign any_sel_d = sel_u_d || sel_l_d || (sel_m_d != 4'h0);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      mode_q <= 3'h0;
      start_q <= 1'b0;
      AREA_READY_MODE <= 3'h0;
    end else begin
      start_q <= CYCLE.start && any_sel_d;
      if (CYCLE.start) begin
        mode_q <= mode_d;
        AREA_READY_MODE <= mode_d;
      end
    end
  end

  mcsd_wait_gen u_wait (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .start(start_q),
    .active((|sel_q) && CYCLE.active),
    .mode(mode_q),
    .ext_ready(EXT_READY),
    .ready(rdy)
  );

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_READY <= 1'b0;
    end else begin
      BUS_READY <= rdy;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_start_upper;
    CYCLE.start && hit_upper;
  endsequence
  a_upper_select_low: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_start_upper |=> !UPPER_AREA_SELECT_N) else $error("upper select missed");
  a_lower_gated_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !lower_seen_q |-> LOWER_AREA_SELECT_N) else $error("lower select before access");
  a_mid_gated_off: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    !(base_seen_q && size_seen_q) |-> MID_AREA_SELECTS_N == 4'hF)
    else $error("mid select before access");
  a_mid_one_hot: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $onehot0(~MID_AREA_SELECTS_N)) else $error("mid selects overlap");
  a_select_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (!CYCLE.start && CYCLE.active) |=> $stable(MID_AREA_SELECTS_N))
    else $error("mid select moved mid cycle");
  a_upper_reset_val: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    $rose(ARST_N) |-> upper_area_limit_q == 16'hFFFB) else $error("upper reset value");
  a_ready_zero_wait: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (start_q && mode_q == 3'h4 && CYCLE.active) ##1 CYCLE.active |=> BUS_READY)
    else $error("no-wait ready late");
  a_ready_three_wait: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (start_q && mode_q[1:0] == 2'h3) |=> !rdy [*3]) else $error("ready too early");
  a_ready_ext_gate: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (BUS_READY && !AREA_READY_MODE[2]) |-> $past(EXT_READY))
    else $error("ready without external ready");
  sequence s_start_lower;
    CYCLE.start && hit_lower && lower_seen_q;
  endsequence
  a_lower_select_low: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_start_lower |=> !LOWER_AREA_SELECT_N) else $error("lower select missed");
  sequence s_start_mid;
    CYCLE.start && mid_armed;
  endsequence
  a_mid_select_quarter: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    s_start_mid |=> (~MID_AREA_SELECTS_N == $past(hit_mid)))
    else $error("mid quarter wrong");
  a_select_release: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (!CYCLE.start && !CYCLE.active) |=> (UPPER_AREA_SELECT_N && LOWER_AREA_SELECT_N &&
    MID_AREA_SELECTS_N == 4'hF)) else $error("select left low after cycle");
  a_upper_lower_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (!CYCLE.start && CYCLE.active) |=> ($stable(UPPER_AREA_SELECT_N) &&
    $stable(LOWER_AREA_SELECT_N))) else $error("upper or lower select moved mid cycle");
  a_ready_idle_low: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (UPPER_AREA_SELECT_N && LOWER_AREA_SELECT_N && MID_AREA_SELECTS_N == 4'hF)
    |=> !BUS_READY) else $error("ready with no select");
  a_upper_mode_out: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (CYCLE.start && sel_u_d && !REG_REQ.wr) |=> AREA_READY_MODE == upper_area_limit_q[2:0])
    else $error("upper ready mode wrong");
  a_lower_mode_out: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (CYCLE.start && sel_l_d && !sel_u_d && !REG_REQ.wr) |=>
    AREA_READY_MODE == lower_area_limit_q[2:0]) else $error("lower ready mode wrong");
  a_mid_mode_out: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (CYCLE.start && sel_m_d != 4'h0 && !sel_u_d && !sel_l_d && !REG_REQ.wr) |=>
    AREA_READY_MODE == mid_area_base_q[2:0]) else $error("mid ready mode wrong");
endmodule : mcsd_top

//--- logic/mcsd_wait_gen.sv
// Purpose: internal ready generator for one selected access
// Assumes: start is a one-cycle pulse at cycle begin
// Notes: count runs beside external ready, not after it
`timescale 1ns/1ps
`include "mcsd_defines.svh"
module mcsd_wait_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic active,
  input wire mcsd_pkg::mcsd_ready_mode_type mode,
  input wire logic ext_ready,
  output logic ready
);
  import mcsd_pkg::*;
  logic [1:0] cnt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
    end else if (start) begin
      cnt_q <= mode[1:0];
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  always_comb begin
    ready = active && !start && (cnt_q == 2'h0) &&
      (mode[`MCSD_RDY_IGNORE_BIT] || ext_ready);
  end
endmodule : mcsd_wait_gen

//--- test/mcsd_mem_model.sv
// Purpose: memory device side, answers selects with external ready
// Assumes: ready asserted after a set number of cycles selected
// Notes: ready cleared on the clock after all memory selects go inactive
`timescale 1ns/1ps
module mcsd_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [5:0] sel_n,
  input wire logic [3:0] delay,
  output logic ext_ready
);
  logic [3:0] cnt_q;
  // Slow or prompt device, delay chosen by the bench
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      ext_ready <= 1'b0;
    end else if (&sel_n) begin
      cnt_q <= 4'h0;
      ext_ready <= 1'b0;
    end else begin
      if (cnt_q < delay) cnt_q <= cnt_q + 4'h1;
      ext_ready <= (cnt_q >= delay);
    end
  end
endmodule : mcsd_mem_model

//--- test/mcsd_top_test.sv
// Purpose: self-checking bench for the chip-select decoder
// Assumes: inputs driven at the falling edge
// Notes: ready latency checked to the exact cycle
`timescale 1ns/1ps
module mcsd_top_test;
  import mcsd_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  mcsd_reg_req_type req = '0;
  mcsd_cycle_type cyc = '0;
  logic [15:0] rdata;
  logic ext_ready, up_n, lo_n, bus_ready;
  logic [3:0] mid_n;
  logic [2:0] mode;
  logic [3:0] dly = 4'h0;
  int n_fail = 0;
  int cmp_count = 0;
  // ----------------------------------------
  // Clock, device and partner
  // ----------------------------------------
  initial forever #5 clk_sys = ~clk_sys;
  mcsd_top DUT (.CLK_SYS(clk_sys), .ARST_N(arst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .CYCLE(cyc), .EXT_READY(ext_ready), .UPPER_AREA_SELECT_N(up_n),
    .LOWER_AREA_SELECT_N(lo_n), .MID_AREA_SELECTS_N(mid_n), .BUS_READY(bus_ready),
    .AREA_READY_MODE(mode));
  mcsd_mem_model mem (.clk(clk_sys), .arst_n(arst_n), .sel_n({up_n, lo_n, mid_n}),
    .delay(dly), .ext_ready(ext_ready));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] off, input logic [15:0] d);
    @(negedge clk_sys);
    req = '{offset: off, data: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] off, input logic [15:0] exp);
    @(negedge clk_sys);
    req = '{offset: off, data: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge clk_sys);
    req.rd = 1'b0;
    chk("rdata", {4'h0, rdata}, {4'h0, exp});
  endtask : rd
  // One bus cycle; lo and hi bound the cycle where ready first shows
  task automatic bc(input logic [19:0] a, input logic [5:0] es, input logic [2:0] em,
      input int lo, input int hi);
    int n;
    @(negedge clk_sys);
    cyc = '{addr: a, start: 1'b1, active: 1'b1};
    @(negedge clk_sys);
    cyc.start = 1'b0;
    n = 1;
    chk("sel", {14'h0, up_n, lo_n, mid_n}, {14'h0, es});
    chk("mode", {17'h0, mode}, {17'h0, em});
    while (bus_ready !== 1'b1 && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    chk("rdy_lat", {19'h0, n >= lo && n <= hi}, 20'h1);
    chk("sel_hold", {14'h0, up_n, lo_n, mid_n}, {14'h0, es});
    cyc.active = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("sel_end", {14'h0, up_n, lo_n, mid_n}, 20'h3F);
  endtask : bc
  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : mx
  // Window for ready: internal count W and partner delay d run in parallel
  task automatic bce(input logic [19:0] a, input logic [5:0] es, input logic [2:0] m);
    int w;
    w = m[1:0];
    if (m[2]) bc(a, es, m, 3 + w, 3 + w);
    else bc(a, es, m, mx(3 + w, 3 + dly), mx(3 + w, 3 + dly));
  endtask : bce
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("rst_sel", {14'h0, up_n, lo_n, mid_n}, 20'h3F);
    arst_n = 1'b1;
    rd(8'hA0, 16'hFFFB);
    rd(8'hA4, 16'h0000);
    $display("TB: test reset done");
  endtask : t_reset
  task automatic t_upper;
    dly = 4'h1;
    bce(20'hFFFF0, 6'h1F, 3'h3);
    bc(20'hFFBFF, 6'h3F, 3'h4, 12, 12);
    bce(20'hFFC00, 6'h1F, 3'h3);
    wr(8'hA0, 16'hF03C);
    bce(20'hF0000, 6'h1F, 3'h4);
    bc(20'hEFFFF, 6'h3F, 3'h4, 12, 12);
    $display("TB: test upper done");
  endtask : t_upper
  task automatic t_lower;
    bc(20'h00000, 6'h3F, 3'h4, 12, 12);
    wr(8'hA2, 16'h0039);
    rd(8'hA2, 16'h0039);
    dly = 4'h4;
    bce(20'h003FF, 6'h2F, 3'h1);
    dly = 4'h0;
    bce(20'h00000, 6'h2F, 3'h1);
    bc(20'h00400, 6'h3F, 3'h4, 12, 12);
    $display("TB: test lower done");
  endtask : t_lower
  task automatic t_mid;
    wr(8'hA6, 16'h1006);
    bc(20'h10000, 6'h3F, 3'h4, 12, 12);
    wr(8'hA8, 16'h0400);
    rd(8'hA8, 16'h0400);
    for (int q = 0; q < 4; q++) begin
      bce(20'(20'h10000 + q * 20'h2000), {2'b11, ~(4'h1 << q)}, 3'h6);
    end
    bce(20'h17FFF, 6'h37, 3'h6);
    bc(20'h18000, 6'h3F, 3'h4, 12, 12);
    bc(20'h0FFFF, 6'h3F, 3'h4, 12, 12);
    $display("TB: test mid done");
  endtask : t_mid
  // Second reset in mid-run: areas disarm, upper back to 1K
  task automatic t_rearm;
    @(negedge clk_sys);
    arst_n = 1'b0;
    @(negedge clk_sys);
    chk("rearm_sel", {14'h0, up_n, lo_n, mid_n}, 20'h3F);
    chk("rearm_rdy", {19'h0, bus_ready}, 20'h0);
    arst_n = 1'b1;
    rd(8'hA0, 16'hFFFB);
    bc(20'h00000, 6'h3F, 3'h4, 12, 12);
    bc(20'h10000, 6'h3F, 3'h4, 12, 12);
    dly = 4'h2;
    bce(20'hFFC00, 6'h1F, 3'h3);
    bc(20'hFF800, 6'h3F, 3'h4, 12, 12);
    wr(8'hA6, 16'h0004);
    wr(8'hA8, 16'h4000);
    bce(20'h00000, 6'h3E, 3'h4);
    bce(20'h7FFFF, 6'h37, 3'h4);
    bc(20'h80000, 6'h3F, 3'h4, 12, 12);
    $display("TB: test rearm done");
  endtask : t_rearm
  task automatic end_sim;
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(negedge clk_sys);
    t_reset();
    t_upper();
    t_lower();
    t_mid();
    t_rearm();
    end_sim();
  end
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end
endmodule : mcsd_top_test
